// [design/cfg_ctrl_defines.svh]
// Constant macros for the configuration control pin block.
`ifndef CFG_CTRL_DEFINES_SVH
`define CFG_CTRL_DEFINES_SVH

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS   100
`define INIT_TIME_NS    1000
`define INIT_CYCLES     ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LCLK_HALF_NS    400
`define LCLK_HALF_CYC   (`LCLK_HALF_NS / `CLK_PERIOD_NS)

// ************************************************************
// Register byte addresses
// ************************************************************
`define ADDR_CTRL       12'h000
`define ADDR_UNUSED     12'h004
`define ADDR_CFG_LEN    12'h008
`define ADDR_STATUS     12'h00C
`define ADDR_IRQ_STAT   12'h010
`define ADDR_IRQ_CLR    12'h014
`define ADDR_IRQ_EN     12'h018
`define ADDR_RB_LEN     12'h01C

// ************************************************************
// Control fields and reset values
// ************************************************************
`define CTRL_RB_EN      0
`define CTRL_GTS_OPT    1
`define CTRL_RST_DIRECT 2
`define CTRL_HOST_EN    3
`define CTRL_DONE_PU    4
`define CTRL_SCAN_EN    5
`define CTRL_W          6
`define CTRL_RST        6'h00
`define CFG_LEN_RST     16'h0100
`define RB_LEN_RST      16'h0100
`define UNUSED_RST      8'h00

// ************************************************************
// Interrupt status bits
// ************************************************************
`define IRQ_LOADED      0
`define IRQ_ERROR       1
`define IRQ_RB_DONE     2
`define IRQ_RESTART     3
`define IRQ_W           4

// ************************************************************
// Sizes and synchroniser lanes
// ************************************************************
`define USER_IO_W       8
`define SYNC_W          18
`define SY_LCLK         0
`define SY_RDCFG        1
`define SY_RESET        2
`define SY_PROG         3
`define SY_DONE         4
`define SY_DIN          5
`define SY_MODE         6
`define SY_DBUS         10

`endif

// [design/cfg_ctrl_pkg.sv]
// Types shared by the configuration control pin block.
package cfg_ctrl_pkg;

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_INIT   = 3'b000,
		ST_LOAD   = 3'b001,
		ST_DONE   = 3'b010,
		ST_USER   = 3'b011,
		ST_RDBACK = 3'b100
	} state_t;

	// Configuration modes chosen by the mode pins.
	typedef enum logic [3:0] {
		MD_MASTER_SER  = 4'h0,
		MD_SLAVE_SER   = 4'h1,
		MD_ASYNC_PERIPH = 4'h2,
		MD_SLAVE_PAR   = 4'h3
	} mode_t;

endpackage : cfg_ctrl_pkg

// [design/cfg_ctrl.sv]
// Configuration control pins, readback and APB register file.
// Behaviour
// - User I/O float with pull-up during configuration
// - Unused pins stay floating with pull-up after
// - Reset pin aborts and restarts configuration
// - After configuration reset pin general or direct
// - Master and async peripheral drive config clock
// - Daisy lead device outputs clock to followers
// - Low completion pin holds off start-up
// - Completion pin open-drain, released high, optional pull-up
// - Program pin low restarts and resets scan
// - Readback control low tristates I/O during configuration
// - Falling readback control starts readback at frame 0
// - Readback pin carries readback or scan data
// - Error output low on RAM init failure
// - Same pin is host port interrupt
// - Mode pins captured at init status rising
// - Active-high and active-low config flags until done
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_ctrl_defines.svh"

module cfg_ctrl (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic                          pready,
	output logic [31:0]                   prdata,
	output logic                          pslverr,
	input  wire logic                     config_clock_in,
	output logic                          config_clock_out,
	output logic                          config_clock_oe_n,
	input  wire logic                     din,
	input  wire logic [7:0]               d_bus,
	input  wire logic [3:0]               mode_sel,
	input  wire logic                     reset_pin_n,
	input  wire logic                     program_restart_n,
	input  wire logic                     rd_cfg_n,
	input  wire logic                     done_in,
	output logic                          done_out,
	output logic                          done_oe_n,
	output logic                          done_pullup_en,
	output logic                          reset_pullup_en,
	output logic                          program_pullup_en,
	input  wire logic                     ram_init_fail,
	input  wire logic                     rb_bit,
	output logic [15:0]                   rb_addr,
	input  wire logic                     scan_tdo,
	output logic                          readback_out,
	output logic                          scan_reset_n,
	output logic                          fabric_async_reset_n,
	output logic                          reset_general_in,
	output logic                          global_tristate,
	input  wire logic [`USER_IO_W-1:0]    user_oe_n,
	output logic [`USER_IO_W-1:0]         user_io_oe_n,
	output logic [`USER_IO_W-1:0]         user_io_pullup,
	output logic                          cfg_active_high,
	output logic                          cfg_active_low,
	output logic                          host_port_irq_n,
	output cfg_ctrl_pkg::state_t          cfg_state
);
	import cfg_ctrl_pkg::*;

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [`SYNC_W-1:0] raw_in;
	logic [`SYNC_W-1:0] sy1_reg;
	logic [`SYNC_W-1:0] sy2_reg;
	logic [`SYNC_W-1:0] sy3_reg;
	logic [`SYNC_W-1:0] filt_reg;

	assign raw_in = {d_bus, mode_sel, din, done_in, program_restart_n, reset_pin_n, rd_cfg_n, config_clock_in};

	// A level counts only once two late stages agree; the first stage feeds nothing else.
	genvar gi;
	generate
		for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sy1_reg[gi]  <= 1'b1;
					sy2_reg[gi]  <= 1'b1;
					sy3_reg[gi]  <= 1'b1;
					filt_reg[gi] <= 1'b1;
				end else begin
					sy1_reg[gi] <= raw_in[gi];
					sy2_reg[gi] <= sy1_reg[gi];
					sy3_reg[gi] <= sy2_reg[gi];
					if (sy2_reg[gi] == sy3_reg[gi]) begin
						filt_reg[gi] <= sy3_reg[gi];
					end
				end
			end
		end
	endgenerate

	logic       lclk_s;
	logic       rdcfg_s;
	logic       prog_s;
	logic       done_s;
	logic [7:0] dbus_s;
	logic       lclk_prev_reg;
	logic       rdcfg_prev_reg;
	logic       ext_rise;
	logic       rdcfg_fall;

	assign lclk_s     = filt_reg[`SY_LCLK];
	assign rdcfg_s    = filt_reg[`SY_RDCFG];
	assign prog_s     = filt_reg[`SY_PROG];
	assign done_s     = filt_reg[`SY_DONE];
	assign dbus_s     = filt_reg[`SY_DBUS +: 8];
	assign ext_rise   = lclk_s & ~lclk_prev_reg;
	assign rdcfg_fall = ~rdcfg_s & rdcfg_prev_reg;

	// Edge history resets to the synchroniser's reset level, so no false edge follows reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lclk_prev_reg  <= 1'b1;
			rdcfg_prev_reg <= 1'b1;
		end else begin
			lclk_prev_reg  <= lclk_s;
			rdcfg_prev_reg <= rdcfg_s;
		end
	end

	// ************************************************************
	// Register file storage
	// ************************************************************
	logic [`CTRL_W-1:0]    ctrl_reg;
	logic [`USER_IO_W-1:0] unused_reg;
	logic [15:0]           cfg_len_reg;
	logic [15:0]           rb_len_reg;
	logic [`IRQ_W-1:0]     irq_stat_reg;
	logic [`IRQ_W-1:0]     irq_en_reg;
	logic [`IRQ_W-1:0]     irq_event;
	logic                  wr_acc;
	logic                  rd_setup;

	assign wr_acc   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;

	// ************************************************************
	// Sequencer
	// ************************************************************
	state_t      state_reg;
	mode_t       mode_reg;
	logic [15:0] init_cnt_reg;
	logic [15:0] bit_cnt_reg;
	logic        err_reg;
	logic        restart;
	logic        self_clock;
	logic        lclk_div_rise;
	logic        data_edge;
	logic        parallel;

	// Program low always restarts; the reset pin only while configuring.
	assign restart = ~prog_s | (~filt_reg[`SY_RESET] & (state_reg != ST_USER) & (state_reg != ST_RDBACK));
	assign self_clock = (mode_reg == MD_MASTER_SER) | (mode_reg == MD_ASYNC_PERIPH);
	assign parallel   = (mode_reg == MD_ASYNC_PERIPH) | (mode_reg == MD_SLAVE_PAR);
	assign data_edge  = self_clock ? lclk_div_rise : ext_rise;

	// State walk: init, load, completion wait, user, readback.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_INIT;
		end else if (restart) begin
			state_reg <= ST_INIT;
		end else begin
			case (state_reg)
				ST_INIT: begin
					// Readback control is assumed high here by the host.
					if (init_cnt_reg == 16'(`INIT_CYCLES - 1)) begin
						state_reg <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (bit_cnt_reg >= cfg_len_reg) begin
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (done_s) begin
						state_reg <= ST_USER;
					end
				end
				ST_USER: begin
					if (ctrl_reg[`CTRL_RB_EN] && rdcfg_fall) begin
						state_reg <= ST_RDBACK;
					end
				end
				ST_RDBACK: begin
					if (rb_addr == rb_len_reg) begin
						state_reg <= ST_USER;
					end
				end
				default: begin
					state_reg <= ST_INIT;
				end
			endcase
		end
	end

	// Init timer; its terminal count is the rising edge of init status.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt_reg <= 16'h0000;
		end else if (restart || state_reg != ST_INIT) begin
			init_cnt_reg <= 16'h0000;
		end else begin
			init_cnt_reg <= init_cnt_reg + 16'h0001;
		end
	end

	// Mode pins are latched as init status rises, on each pass through init.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= MD_SLAVE_SER;
		end else if (!restart && state_reg == ST_INIT && init_cnt_reg == 16'(`INIT_CYCLES - 1)) begin
			mode_reg <= mode_t'(filt_reg[`SY_MODE +: 4]);
		end
	end

	// Count configuration bits; a parallel strobe carries eight.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_reg <= 16'h0000;
		end else if (restart || state_reg == ST_INIT) begin
			bit_cnt_reg <= 16'h0000;
		end else if (state_reg == ST_LOAD && data_edge) begin
			bit_cnt_reg <= bit_cnt_reg + (parallel ? 16'h0008 : 16'h0001);
		end
	end

	// Init failure of block RAM is sticky until the next restart.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_reg <= 1'b0;
		end else if (restart) begin
			err_reg <= 1'b0;
		end else if (state_reg == ST_LOAD && ram_init_fail) begin
			err_reg <= 1'b1;
		end
	end

	// ************************************************************
	// Configuration clock divider
	// ************************************************************
	logic [7:0] div_cnt_reg;
	logic       lclk_out_reg;
	logic       div_tick;

	assign div_tick      = (div_cnt_reg == 8'(`LCLK_HALF_CYC - 1));
	assign lclk_div_rise = div_tick & ~lclk_out_reg;

	// The clock runs only while loading, so followers see no stray edges.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg  <= 8'h00;
			lclk_out_reg <= 1'b0;
		end else if (state_reg != ST_LOAD || !self_clock) begin
			div_cnt_reg  <= 8'h00;
			lclk_out_reg <= 1'b0;
		end else if (div_tick) begin
			div_cnt_reg  <= 8'h00;
			lclk_out_reg <= ~lclk_out_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end

	// ************************************************************
	// Readback
	// ************************************************************
	logic rb_data_reg;

	// Each external clock rise shifts one bit out and moves to the next frame.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rb_addr     <= 16'h0000;
			rb_data_reg <= 1'b0;
		end else if (state_reg != ST_RDBACK) begin
			rb_addr <= 16'h0000;
		end else if (ext_rise) begin
			rb_data_reg <= rb_bit;
			rb_addr     <= rb_addr + 16'h0001;
		end
	end

	// ************************************************************
	// Pin drivers
	// ************************************************************
	logic in_config;
	logic active_reg;

	assign in_config = (state_reg == ST_INIT) | (state_reg == ST_LOAD) | (state_reg == ST_DONE);

	// Flags are registered so both polarities switch on the same edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_reg <= 1'b1;
		end else begin
			active_reg <= in_config;
		end
	end

	assign cfg_active_high   = active_reg;
	assign cfg_active_low    = ~active_reg;
	assign config_clock_out  = lclk_out_reg;
	assign config_clock_oe_n = ~(self_clock & (state_reg == ST_LOAD));
	assign done_out          = 1'b0;
	assign done_oe_n         = ~(state_reg == ST_INIT || state_reg == ST_LOAD);
	assign done_pullup_en    = ctrl_reg[`CTRL_DONE_PU];
	assign reset_pullup_en   = in_config;
	assign program_pullup_en = 1'b1;
	assign scan_reset_n      = prog_s;
	assign readback_out      = ctrl_reg[`CTRL_SCAN_EN] ? scan_tdo : rb_data_reg;
	assign cfg_state         = state_reg;

	// The direct path is deliberately unsynchronised so it acts without a clock.
	assign fabric_async_reset_n = ~(~in_config & ctrl_reg[`CTRL_RST_DIRECT] & ~reset_pin_n);
	assign reset_general_in     = ~in_config & ~ctrl_reg[`CTRL_RST_DIRECT] & ~filt_reg[`SY_RESET];

	// Readback control forces tristate while configuring, and after only if optioned.
	assign global_tristate = in_config ? ~rdcfg_s : (ctrl_reg[`CTRL_GTS_OPT] & ~rdcfg_s);

	// Per-pin enables: float with pull-up while configuring or when unused.
	generate
		for (gi = 0; gi < `USER_IO_W; gi = gi + 1) begin : g_io
			assign user_io_oe_n[gi]   = in_config | global_tristate | unused_reg[gi] | user_oe_n[gi];
			assign user_io_pullup[gi] = in_config | unused_reg[gi];
		end
	endgenerate

	// ************************************************************
	// Interrupts
	// ************************************************************
	logic loaded_ev;

	assign loaded_ev = (state_reg == ST_LOAD) & (bit_cnt_reg >= cfg_len_reg) & ~restart;

	always_comb begin
		irq_event               = '0;
		irq_event[`IRQ_LOADED]  = loaded_ev;
		irq_event[`IRQ_ERROR]   = (state_reg == ST_LOAD) & ram_init_fail & ~err_reg;
		irq_event[`IRQ_RB_DONE] = (state_reg == ST_RDBACK) & (rb_addr == rb_len_reg) & ~restart;
		irq_event[`IRQ_RESTART] = restart & (state_reg != ST_INIT);
	end

	// A new event wins over a clear written in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
		end else if (wr_acc && paddr == `ADDR_IRQ_CLR) begin
			irq_stat_reg <= (irq_stat_reg & ~pwdata[`IRQ_W-1:0]) | irq_event;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_event;
		end
	end

	// Pin shared between configuration error and host port interrupt.
	assign host_port_irq_n = ctrl_reg[`CTRL_HOST_EN] ? ~(|(irq_stat_reg & irq_en_reg)) : ~err_reg;

	// ************************************************************
	// APB slave
	// ************************************************************
	// Writes land at the access edge; every access completes with no wait.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg    <= `CTRL_RST;
			unused_reg  <= `UNUSED_RST;
			cfg_len_reg <= `CFG_LEN_RST;
			rb_len_reg  <= `RB_LEN_RST;
			irq_en_reg  <= '0;
		end else if (wr_acc) begin
			case (paddr)
				`ADDR_CTRL:    ctrl_reg    <= pwdata[`CTRL_W-1:0];
				`ADDR_UNUSED:  unused_reg  <= pwdata[`USER_IO_W-1:0];
				`ADDR_CFG_LEN: cfg_len_reg <= pwdata[15:0];
				`ADDR_RB_LEN:  rb_len_reg  <= pwdata[15:0];
				`ADDR_IRQ_EN:  irq_en_reg  <= pwdata[`IRQ_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// Read data and the error flag are captured in the setup cycle.
	logic slverr_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= 32'h00000000;
			slverr_reg <= 1'b0;
		end else if (rd_setup) begin
			slverr_reg <= 1'b0;
			prdata     <= 32'h00000000;
			case (paddr)
				`ADDR_CTRL:     prdata <= {26'h0000000, ctrl_reg};
				`ADDR_UNUSED:   prdata <= {24'h000000, unused_reg};
				`ADDR_CFG_LEN:  prdata <= {16'h0000, cfg_len_reg};
				`ADDR_STATUS:   prdata <= {23'h000000, state_reg == ST_RDBACK, err_reg, mode_reg, state_reg};
				`ADDR_IRQ_STAT: prdata <= {28'h0000000, irq_stat_reg};
				`ADDR_IRQ_CLR:  prdata <= 32'h00000000;
				`ADDR_IRQ_EN:   prdata <= {28'h0000000, irq_en_reg};
				`ADDR_RB_LEN:   prdata <= {16'h0000, rb_len_reg};
				default: begin
					slverr_reg <= 1'b1;
				end
			endcase
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & slverr_reg;

endmodule : cfg_ctrl
`default_nettype wire

// [tb/cfg_ctrl_props.sv]
// Concurrent checks on the configuration control pins.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_ctrl_defines.svh"
module cfg_ctrl_props (
	input wire logic			pclk,
	input wire logic			presetn,
	input wire cfg_ctrl_pkg::state_t	cfg_state,
	input wire logic			cfg_active_high,
	input wire logic			cfg_active_low,
	input wire logic [`USER_IO_W-1:0]	user_io_oe_n,
	input wire logic [`USER_IO_W-1:0]	user_io_pullup,
	input wire logic			done_oe_n,
	input wire logic			done_in,
	input wire logic			program_restart_n,
	input wire logic			scan_reset_n,
	input wire logic			reset_pin_n,
	input wire logic			rd_cfg_n,
	input wire logic			global_tristate,
	input wire logic			config_clock_oe_n,
	input wire logic [15:0]			rb_addr,
	input wire logic			reset_pullup_en,
	input wire logic			program_pullup_en
);
	import cfg_ctrl_pkg::*;
	// One clock domain, so clocking and disable are given once.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ********************
	// Assertions
	// ********************
	flags_compl_a: assert property (cfg_active_high != cfg_active_low)
		else $error("Config flags not complementary.");
	io_float_a: assert property (cfg_state == ST_LOAD |-> &user_io_oe_n && &user_io_pullup)
		else $error("User pin driven while loading.");
	done_hold_a: assert property (cfg_state == ST_DONE && !done_in |=> cfg_state != ST_USER)
		else $error("Start-up while completion pin low.");
	done_release_a: assert property (cfg_state == ST_USER |-> done_oe_n)
		else $error("Completion pin not released.");
	// Synchroniser lag is allowed for, so the pin must stay low for five cycles first.
	gts_cfg_a: assert property ((cfg_state == ST_LOAD && !rd_cfg_n) [*5] |-> global_tristate && &user_io_oe_n)
		else $error("Tristate missing while loading.");
	rb_start_a: assert property ($rose(cfg_state == ST_RDBACK) |-> rb_addr == 16'h0000)
		else $error("Readback not at frame zero.");
	prog_restart_a: assert property ($fell(program_restart_n) |-> ##[1:6] (cfg_state == ST_INIT && !scan_reset_n))
		else $error("Program pin did not restart.");
	pin_restart_a: assert property ($fell(reset_pin_n) && cfg_state == ST_LOAD |-> ##[1:6] cfg_state == ST_INIT)
		else $error("Reset pin did not restart.");
	pullups_a: assert property (program_pullup_en && (cfg_state != ST_LOAD || reset_pullup_en))
		else $error("Pin pull-up missing.");
	rdback_clk_a: assert property (cfg_state == ST_RDBACK |-> config_clock_oe_n)
		else $error("Clock driven during readback.");
	// Main scenarios reached.
	cover property ($rose(cfg_state == ST_USER));
	cover property ($rose(cfg_state == ST_RDBACK));
	cover property (!config_clock_oe_n);
endmodule : cfg_ctrl_props

bind cfg_ctrl cfg_ctrl_props u_props (
	.pclk, .presetn, .cfg_state, .cfg_active_high, .cfg_active_low, .user_io_oe_n, .user_io_pullup,
	.done_oe_n, .done_in, .program_restart_n, .scan_reset_n, .reset_pin_n, .rd_cfg_n,
	.global_tristate, .config_clock_oe_n, .rb_addr, .reset_pullup_en, .program_pullup_en
);
`default_nettype wire

// [tb/cfg_host_model.sv]
// External configuration host that supplies the link clock and data.
`timescale 1ns/10ps
`default_nettype none
module cfg_host_model (
	input wire logic	start,
	input wire logic [15:0]	n_edges,
	output logic		lclk,
	output logic		din,
	output logic [7:0]	d_bus
);
	// The clock stands low between frames.
	initial begin
		lclk = 1'b0;
		din = 1'b1;
		d_bus = 8'hA5;
	end
	// The odd start offset keeps the link out of phase with the bus clock.
	always @(posedge start) begin
		#37;
		repeat (n_edges) begin
			#400 lclk = 1'b1;
			#400 lclk = 1'b0;
			din = ~din;
			d_bus = ~d_bus;
		end
	end
endmodule : cfg_host_model
`default_nettype wire

// [tb/tb_fpga_config_control_pins.sv]
// Self-checking testbench for the configuration control pins.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_ctrl_defines.svh"
module tb_fpga_config_control_pins;
	import cfg_ctrl_pkg::*;
	logic			pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0]		paddr;
	logic [31:0]		pwdata, prdata, rdata;
	logic			lclk_pin, host_clk, hstart, din, lclk_out, lclk_oe_n, rb_bit, done_pu;
	logic [15:0]		hn, rb_addr;
	logic [7:0]		d_bus;
	logic [3:0]		mode_sel;
	logic			reset_pin_n, program_restart_n, rd_cfg_n, done_in, done_ext, done_out, done_oe_n;
	logic			reset_pullup_en, program_pullup_en, ram_init_fail, scan_tdo, readback_out;
	logic			scan_reset_n, fabric_async_reset_n, reset_general_in, global_tristate;
	logic			cfg_active_high, cfg_active_low, host_port_irq_n;
	logic [`USER_IO_W-1:0]	user_oe_n, user_io_oe_n, user_io_pullup;
	state_t			cfg_state;
	int			mismatches, num_checks;

	// Shared pins resolve from the device's enable alone; the host side has none.
	assign done_in = done_oe_n ? done_ext : done_out;
	assign lclk_pin = lclk_oe_n ? host_clk : lclk_out;
	assign rb_bit = rb_addr[0];

	cfg_ctrl dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.config_clock_in(lclk_pin), .config_clock_out(lclk_out), .config_clock_oe_n(lclk_oe_n),
		.din, .d_bus, .mode_sel, .reset_pin_n, .program_restart_n, .rd_cfg_n, .done_in, .done_out,
		.done_oe_n, .done_pullup_en(done_pu), .reset_pullup_en, .program_pullup_en, .ram_init_fail, .rb_bit,
		.rb_addr, .scan_tdo, .readback_out, .scan_reset_n, .fabric_async_reset_n, .reset_general_in,
		.global_tristate, .user_oe_n, .user_io_oe_n, .user_io_pullup, .cfg_active_high,
		.cfg_active_low, .host_port_irq_n, .cfg_state
	);
	cfg_host_model host (.start(hstart), .n_edges(hn), .lclk(host_clk), .din, .d_bus);

	// Bus clock.
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ********************
	// Shared tasks
	// ********************
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d.", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h, expected %h.", $time, got, exp);
		end
	endtask : chk

	// One transfer; entered just after an edge and left one edge after release.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			if (n++ > 16) begin
				mismatches++;
				end_of_test();
			end
			@(posedge pclk);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask : rd

	// A wait that never hangs: running out counts as a mismatch.
	task automatic wait_st(input state_t s);
		int n;
		n = 0;
		while (cfg_state !== s) begin
			if (n++ > 3000) begin
				mismatches++;
				end_of_test();
			end
			@(posedge pclk);
		end
	endtask : wait_st

	task automatic send(input logic [15:0] n);
		hn <= n;
		hstart <= 1'b1;
		@(posedge pclk);
		hstart <= 1'b0;
	endtask : send

	// ********************
	// Scenarios
	// ********************
	task automatic t_regs();
		rd(`ADDR_CTRL, 32'(`CTRL_RST));
		rd(`ADDR_CFG_LEN, 32'(`CFG_LEN_RST));
		rd(`ADDR_RB_LEN, 32'(`RB_LEN_RST));
		chk(32'(rerr), 32'h0);
		rd(12'h020, 32'h0);
		chk(32'(rerr), 32'h1);
		wr(`ADDR_CFG_LEN, 32'h4);
		wr(`ADDR_UNUSED, 32'hF);
		wr(`ADDR_IRQ_EN, 32'hF);
		wr(`ADDR_IRQ_CLR, 32'hF);
		wr(`ADDR_CTRL, 32'h8);
		rd(`ADDR_STATUS, 32'h9);
		$display("Test regs done.");
	endtask : t_regs

	task automatic t_load();
		chk(32'({user_io_oe_n, user_io_pullup}), 32'hFFFF);
		chk(32'({cfg_active_high, cfg_active_low, lclk_oe_n}), 32'h5);
		chk(32'(host_port_irq_n), 32'h1);
		send(16'h4);
		wait_st(ST_DONE);
		repeat (20) @(posedge pclk);
		chk(32'(cfg_state), 32'(ST_DONE));
		chk(32'(host_port_irq_n), 32'h0);
		wr(`ADDR_IRQ_CLR, 32'h1);
		chk(32'(host_port_irq_n), 32'h1);
		done_ext <= 1'b1;
		wait_st(ST_USER);
		repeat (2) @(posedge pclk);
		chk(32'({cfg_active_high, cfg_active_low, done_oe_n}), 32'h3);
		chk(32'({user_io_oe_n, user_io_pullup[3:0]}), 32'h0FF);
		$display("Test load done.");
	endtask : t_load

	task automatic t_rdback();
		wr(`ADDR_RB_LEN, 32'h4);
		wr(`ADDR_IRQ_EN, 32'h0);
		wr(`ADDR_CTRL, 32'h9);
		rd_cfg_n <= 1'b0;
		wait_st(ST_RDBACK);
		chk(32'(rb_addr), 32'h0);
		rd_cfg_n <= 1'b1;
		send(16'h4);
		wait_st(ST_USER);
		chk(32'(rb_addr), 32'h4);
		rd(`ADDR_IRQ_STAT, 32'h4);
		chk(32'(host_port_irq_n), 32'h1);
		wr(`ADDR_IRQ_EN, 32'h4);
		chk(32'(host_port_irq_n), 32'h0);
		wr(`ADDR_IRQ_CLR, 32'h4);
		chk(32'(host_port_irq_n), 32'h1);
		wr(`ADDR_CTRL, 32'h20);
		scan_tdo <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(32'(readback_out), 32'h1);
		scan_tdo <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'(readback_out), 32'h0);
		$display("Test readback done.");
	endtask : t_rdback

	task automatic t_pins();
		wr(`ADDR_CTRL, 32'h14);
		chk(32'(done_pu), 32'h1);
		reset_pin_n <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'({fabric_async_reset_n, cfg_state}), 32'(ST_USER));
		reset_pin_n <= 1'b1;
		wr(`ADDR_CTRL, 32'h0);
		reset_pin_n <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(32'({fabric_async_reset_n, reset_general_in}), 32'h3);
		reset_pin_n <= 1'b1;
		repeat (6) @(posedge pclk);
		$display("Test reset pin done.");
	endtask : t_pins

	task automatic t_restart();
		program_restart_n <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(32'({scan_reset_n, cfg_state}), 32'(ST_INIT));
		program_restart_n <= 1'b1;
		wait_st(ST_LOAD);
		rd_cfg_n <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(32'({global_tristate, user_io_oe_n}), 32'h1FF);
		rd_cfg_n <= 1'b1;
		ram_init_fail <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'(host_port_irq_n), 32'h0);
		ram_init_fail <= 1'b0;
		mode_sel <= 4'h0;
		reset_pin_n <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(32'(cfg_state), 32'(ST_INIT));
		reset_pin_n <= 1'b1;
		wait_st(ST_LOAD);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk(32'(rdata[6:0]), 32'h01);
		chk(32'(lclk_oe_n), 32'h0);
		wait_st(ST_USER);
		$display("Test restart done.");
	endtask : t_restart

	// Inputs start idle with the readback pin high through initialisation.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		hstart = 1'b0;
		hn = 16'h0;
		mode_sel = 4'h1;
		reset_pin_n = 1'b1;
		program_restart_n = 1'b1;
		rd_cfg_n = 1'b1;
		done_ext = 1'b0;
		ram_init_fail = 1'b0;
		scan_tdo = 1'b0;
		user_oe_n = '0;
		mismatches = 0;
		num_checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_load();
		t_rdback();
		t_pins();
		wr(`ADDR_CTRL, 32'h0);
		t_restart();
		end_of_test();
	end
endmodule : tb_fpga_config_control_pins
`default_nettype wire
